// *** bench/array_control_assertions.sv ***
// Purpose: Port checks for array_control.
// Assumes: Mode outputs follow a write two edges later.
// Notes:   Bound to every instance.
`timescale 1ns/1ps
`default_nettype none
module array_control_assertions (
	// Clock, reset and register port
	input wire logic        mclk_in,
	input wire logic        srst_in,
	input wire logic        reg_sel_in,
	input wire logic        reg_wr_in,
	input wire logic [11:0] reg_addr_in,
	input wire logic [31:0] reg_wdata_in,
	// Watched levels
	input wire logic [15:0] weight_memory_addr_in,
	input wire logic [15:0] normal_addr_in,
	input wire logic [15:0] mem_addr_out,
	input wire logic        packer_active_out,
	input wire logic [3:0]  fast_mem_we_out,
	input wire logic        quad_pack_out,
	input wire logic        pool_wait_out,
	input wire logic [5:0]  queue_clk_delay_out,
	input wire logic        accum_en_out,
	input wire logic        weight_reload_out,
	input wire logic        streaming_out
);
	// --------
	// Properties
	// --------
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (srst_in);
	wire wr_hit = reg_sel_in && reg_wr_in && reg_addr_in == 12'h000;
	chk_quad_pack: assert property (
		wr_hit |-> ##2 quad_pack_out == $past(reg_wdata_in[31], 2))
		else $error("quad pack wrong");
	chk_mode_bits: assert property (
		wr_hit |-> ##2 {pool_wait_out, streaming_out}
		== {$past(reg_wdata_in[30], 2), $past(reg_wdata_in[14], 2)}) else $error("mode bit wrong");
	chk_qclk_delay: assert property (
		wr_hit |-> ##2 queue_clk_delay_out == $past(reg_wdata_in[29:24], 2))
		else $error("queue delay wrong");
	chk_fast_we: assert property (
		wr_hit |-> ##2 fast_mem_we_out == ($past(reg_wdata_in[22], 2)
		? ($past(reg_wdata_in[23], 2) ? 4'hF : 4'h1) : 4'h0)) else $error("fast enable wrong");
	chk_accum_off: assert property (
		wr_hit |-> ##2 accum_en_out == !$past(reg_wdata_in[21], 2))
		else $error("accumulator enable wrong");
	chk_reload_quiet: assert property (
		$stable(weight_memory_addr_in[15:8]) |=> !weight_reload_out)
		else $error("reload without change");
	chk_packer_load: assert property (
		wr_hit |=> packer_active_out == $past(reg_wdata_in[16]))
		else $error("packer active wrong");
	chk_normal_addr: assert property (
		!packer_active_out |=> mem_addr_out == $past(normal_addr_in))
		else $error("address source wrong");
endmodule // array_control_assertions
bind array_control array_control_assertions i_chk (
	.mclk_in, .srst_in, .reg_sel_in, .reg_wr_in, .reg_addr_in, .reg_wdata_in,
	.weight_memory_addr_in, .normal_addr_in, .mem_addr_out, .packer_active_out,
	.fast_mem_we_out, .quad_pack_out, .pool_wait_out, .queue_clk_delay_out,
	.accum_en_out, .weight_reload_out, .streaming_out);
`default_nettype wire

// *** bench/array_control_tb.sv ***
// Purpose: Register and steering tests for array_control.
// Assumes: Outputs settle within three edges of a write.
// Notes:   Inputs change 1 ns after the edge.
`timescale 1ns/1ps
`default_nettype none
module array_control_tb;
	// --------
	// Signals
	// --------
	logic         mclk_in = 1'h0, srst_in = 1'h1, reg_sel_in = 1'h0, reg_wr_in = 1'h0;
	logic [11:0]  reg_addr_in = 12'h000;
	logic [31:0]  reg_wdata_in = 32'h0, qw = 32'hA1B2C3D4, layer_data_in = 32'h11223344;
	logic [31:0]  tx_queue_in = 32'h55667788, mem_rdata_in = 32'hDDCCBBAA;
	logic [31:0]  reg_rdata_out, first_layer_data_out, fast_mem_data_out;
	logic [15:0]  layer_write_pointer_base_in = 16'h0, layer_read_pointer_base_in = 16'h0;
	logic [15:0]  read_buffer_end_in = 16'h0, weight_memory_addr_in = 16'h0;
	logic [15:0]  normal_addr_in = 16'h0, mem_addr_out, read_ptr_out;
	logic         read_buffer_step_in = 1'h0, packer_step_in = 1'h0, avg_pool_in = 1'h1;
	logic         wide_data_in = 1'h0, packer_active_out, quad_pack_out, pool_wait_out;
	logic         one_bit_weights_out, accum_en_out, weight_reload_out, streaming_out;
	logic [3:0]   chan_en_in = 4'h0, fast_mem_we_out;
	logic [9:0]   pool_sum_in = 10'h006;
	logic [127:0] proc_data_out;
	logic [5:0]   queue_clk_delay_out;
	logic [1:0]   queue_mode_out;
	logic [7:0]   packed_byte_out, pooled_out;
	integer       failures = 0, n_tests = 0, i;
	always #4 mclk_in = ~mclk_in;
	array_control i_dut (.mclk_in, .srst_in, .reg_sel_in, .reg_wr_in, .reg_addr_in,
		.reg_wdata_in, .reg_rdata_out, .layer_write_pointer_base_in, .layer_read_pointer_base_in,
		.read_buffer_end_in, .read_buffer_step_in, .avg_pool_in, .wide_data_in, .chan_en_in,
		.weight_memory_addr_in, .normal_addr_in, .packer_step_in, .mem_addr_out,
		.packer_active_out, .queue_write_register_in(qw), .tx_queue_in, .layer_data_in,
		.mem_rdata_in, .pool_sum_in, .first_layer_data_out, .proc_data_out, .fast_mem_data_out,
		.fast_mem_we_out, .quad_pack_out, .pool_wait_out, .queue_clk_delay_out,
		.one_bit_weights_out, .accum_en_out, .weight_reload_out, .read_ptr_out, .streaming_out,
		.queue_mode_out, .packed_byte_out, .pooled_out);
	task chk(input [127:0] seen, input [127:0] expd);
		n_tests = n_tests + 1;
		if (seen !== expd) begin
			failures = failures + 1;
			$display("wrong value %0t ns: %h, expected %h", $time, seen, expd);
		end
	endtask
	task tick(input integer n);
		repeat (n) @(posedge mclk_in) #1;
	endtask
	// Request held over exactly one sampling edge
	task acc(input w, input [11:0] a, input [31:0] d);
		tick(1);
		reg_sel_in = 1'h1;
		reg_wr_in = w;
		reg_addr_in = a;
		reg_wdata_in = d;
		tick(1);
		reg_sel_in = 1'h0;
	endtask
	task rd(input [11:0] a, input [31:0] e);
		acc(1'h0, a, 32'h0);
		chk(reg_rdata_out, e);
	endtask
	task setw(input [31:0] d);
		acc(1'h1, 12'h000, d);
		tick(3);
	endtask
	task pulse;
		tick(1);
		packer_step_in = 1'h1;
		read_buffer_step_in = 1'h1;
		tick(1);
		packer_step_in = 1'h0;
		read_buffer_step_in = 1'h0;
		tick(2);
	endtask
	task pulses(input [15:0] a, input integer e);
		integer k;
		k = 0;
		weight_memory_addr_in = a;
		repeat (4) begin
			tick(1);
			k = k + weight_reload_out;
		end
		chk(k, e);
	endtask
	task results;
		$display("comparisons %0d, mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// Bound far above the 164 cycles the tests need
	initial begin
		#20000;
		failures = failures + 1;
		results;
	end
	initial begin
		repeat (12) @(posedge mclk_in);
		#1 srst_in = 1'h0;
		rd(12'h000, 32'h0);
		chk({accum_en_out, quad_pack_out, fast_mem_we_out}, 6'h20);
		setw(32'h0040_0000);
		setw(32'hFFFF_FFFF);
		rd(12'h000, 32'hFFFF_E000);
		chk({quad_pack_out, pool_wait_out, one_bit_weights_out, accum_en_out}, 4'hE);
		chk({streaming_out, queue_clk_delay_out}, 7'h7F);
		acc(1'h1, 12'h004, 32'h0);
		rd(12'h000, 32'hFFFF_E000);
		$display("test fields done");
		setw(32'h0000_8000);
		chk(first_layer_data_out, qw);
		chk(proc_data_out, {96'h0, qw});
		setw(32'h0040_0000);
		chk(first_layer_data_out, layer_data_in);
		chk({fast_mem_we_out, fast_mem_data_out}, {4'h1, tx_queue_in});
		setw(32'h00C0_8000);
		setw(32'h80C0_8000);
		chk(proc_data_out, {4{qw}});
		setw(32'h0080_8000);
		chk(proc_data_out, {24'h0, qw[31:24], 24'h0, qw[23:16],
			24'h0, qw[15:8], 24'h0, qw[7:0]});
		chk({fast_mem_we_out, fast_mem_data_out}, 36'h0);
		for (i = 0; i < 4; i = i + 1) begin
			setw(i << 17);
			chk(packed_byte_out, (mem_rdata_in >> (8 * i)) & 32'h0000_00FF);
		end
		$display("test steering done");
		setw(32'h0000_2000);
		chk(pooled_out, 8'h02);
		avg_pool_in = 1'h0;
		tick(2);
		chk(pooled_out, 8'h01);
		avg_pool_in = 1'h1;
		pool_sum_in = 10'h3FE;
		tick(3);
		chk(pooled_out, 8'h00);
		setw(32'h0);
		chk(pooled_out, 8'hFF);
		wide_data_in = 1'h1;
		tick(2);
		chk(queue_mode_out, 2'h1);
		wide_data_in = 1'h0;
		chan_en_in = 4'hF;
		tick(2);
		chk(queue_mode_out, 2'h2);
		chan_en_in = 4'h7;
		tick(2);
		chk(queue_mode_out, 2'h0);
		$display("test pool and queue done");
		layer_write_pointer_base_in = 16'h0123;
		normal_addr_in = 16'h0F00;
		setw(32'h0001_0000);
		chk({packer_active_out, mem_addr_out}, 17'h10123);
		pulse;
		chk(mem_addr_out, 16'h0124);
		setw(32'h0001_0000);
		chk(mem_addr_out, 16'h0124);
		setw(32'h0);
		chk({packer_active_out, mem_addr_out}, 17'h00F00);
		layer_read_pointer_base_in = 16'h0040;
		read_buffer_end_in = 16'h0041;
		setw(32'h0008_4000);
		chk(read_ptr_out, 16'h0040);
		pulse;
		chk(read_ptr_out, 16'h0041);
		pulse;
		chk(read_ptr_out, 16'h0040);
		setw(32'h0010_0000);
		pulses(16'h0100, 1);
		pulses(16'h0101, 0);
		setw(32'h0);
		pulses(16'h0200, 0);
		$display("test address done");
		setw(32'h0040_0000);
		setw(32'hFFFF_E000);
		srst_in = 1'h1;
		tick(2);
		srst_in = 1'h0;
		rd(12'h000, 32'h0);
		chk({accum_en_out, quad_pack_out, streaming_out}, 3'h4);
		$display("test reset again done");
		results;
	end
endmodule // array_control_tb
`default_nettype wire

// *** hdl/array_control.v ***
// Purpose: Upper half of the per-array control register and its datapath steering.
// Assumes: Single-cycle register port; writes take effect at the next edge.
// Notes:   Unimplemented low bits read as zero.
// What this block does
// - Quad-pack bit makes all four processor lanes take the same input data.
// - Pooling time-shift bit adds one pooling wait state.
// - Six-bit field sets queue clock delay, zero minimum, 0x3F maximum.
// - Grouping bit routes small-data channels to first four processors.
// - Fast queue feeds data memories, one byte per four channels.
// - One-bit weight bit disables accumulators and uses one-bit logic.
// - Express bit reloads packed weights when upper weight address changes.
// - Small-buffer bit, with streaming bit also set, makes read buffer circular from read-pointer base.
// - Packed channel select picks one of four read bytes.
// - Rising write of packer load loads counter and selects it as address.
// - Queue enable takes first-layer data from the queue write register.
// - Queue mode is one byte, one wide, or four byte channels.
// - Streaming bit puts the array into streaming mode.
// - Pool rounding rounds average results half up.
// - All fields return to reset value on any reset.
`timescale 1ns/1ps
`default_nettype none
`include "array_control_regs.vh"

module array_control (
	// Clock and reset
	input  wire        mclk_in,
	input  wire        srst_in,
	// Register port
	input  wire        reg_sel_in,
	input  wire        reg_wr_in,
	input  wire [11:0] reg_addr_in,
	input  wire [31:0] reg_wdata_in,
	output reg  [31:0] reg_rdata_out,
	// Layer context
	input  wire [15:0] layer_write_pointer_base_in,
	input  wire [15:0] layer_read_pointer_base_in,
	input  wire [15:0] read_buffer_end_in,
	input  wire        read_buffer_step_in,
	input  wire        avg_pool_in,
	input  wire        wide_data_in,
	input  wire [3:0]  chan_en_in,
	// Weight memory address
	input  wire [15:0] weight_memory_addr_in,
	// Memory address source
	input  wire [15:0] normal_addr_in,
	input  wire        packer_step_in,
	output reg  [15:0] mem_addr_out,
	output reg         packer_active_out,
	// Data inputs
	input  wire [31:0] queue_write_register_in,
	input  wire [31:0] tx_queue_in,
	input  wire [31:0] layer_data_in,
	input  wire [31:0] mem_rdata_in,
	input  wire [9:0]  pool_sum_in,
	// Steering outputs
	output reg  [31:0] first_layer_data_out,
	output reg  [127:0] proc_data_out,
	output reg  [31:0] fast_mem_data_out,
	output reg  [3:0]  fast_mem_we_out,
	output reg         quad_pack_out,
	output reg         pool_wait_out,
	output reg  [5:0]  queue_clk_delay_out,
	output reg         one_bit_weights_out,
	output reg         accum_en_out,
	output reg         weight_reload_out,
	output reg  [15:0] read_ptr_out,
	output reg         streaming_out,
	output reg  [1:0]  queue_mode_out,
	output wire [7:0]  packed_byte_out,
	output wire [7:0]  pooled_out
);

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	function hit;
		input        sel;
		input [11:0] addr;
		begin
			hit = sel & (addr == `AC_OFFSET);
		end
	endfunction

	// Grouped routing opens all four byte lanes of the fast queue
	function [3:0] fast_lanes;
		input fast;
		input group;
		begin
			if (!fast) begin
				fast_lanes = 4'h0;
			end else if (group) begin
				fast_lanes = 4'hF;
			end else begin
				fast_lanes = 4'h1;
			end
		end
	endfunction

	// Wide data outranks the channel enables
	function [1:0] queue_mode_of;
		input       wide;
		input [3:0] chans;
		begin
			if (wide) begin
				queue_mode_of = `QMODE_WIDE;
			end else if (chans == 4'hF) begin
				queue_mode_of = `QMODE_FOUR_BYTE;
			end else begin
				queue_mode_of = `QMODE_ONE_BYTE;
			end
		end
	endfunction

	reg  [31:0] ctrl_q;
	reg  [31:0] ctrl_d;
	reg  [15:0] packer_cnt_q;
	reg  [15:0] waddr_prev_q;
	wire        wr_hit;
	wire        load_rise;

	assign wr_hit    = hit(reg_sel_in, reg_addr_in) & reg_wr_in;
	// Edge is taken against the stored bit, so rewriting 1 does nothing
	assign load_rise = wr_hit & reg_wdata_in[`AC_PACKER_LOAD] & ~ctrl_q[`AC_PACKER_LOAD];

	// ----------------------------------------
	// Control register
	// ----------------------------------------
	always @* begin
		ctrl_d = ctrl_q;
		if (wr_hit) begin
			ctrl_d = reg_wdata_in & `AC_IMPL_MASK;
		end
	end

	always @(posedge mclk_in) begin
		if (srst_in) begin
			ctrl_q <= `AC_RESET;
		end else begin
			ctrl_q <= ctrl_d;
		end
	end

	always @(posedge mclk_in) begin
		if (srst_in) begin
			reg_rdata_out <= 32'h0000_0000;
		end else if (hit(reg_sel_in, reg_addr_in) & ~reg_wr_in) begin
			reg_rdata_out <= ctrl_q;
		end else begin
			reg_rdata_out <= 32'h0000_0000;
		end
	end

	// ----------------------------------------
	// Packer address counter
	// ----------------------------------------
	always @(posedge mclk_in) begin
		if (srst_in) begin
			packer_cnt_q      <= 16'h0000;
			packer_active_out <= 1'b0;
		end else if (load_rise) begin
			packer_cnt_q      <= layer_write_pointer_base_in;
			packer_active_out <= 1'b1;
		end else begin
			if (packer_active_out & packer_step_in) begin
				packer_cnt_q <= packer_cnt_q + 16'h0001;
			end
			if (wr_hit & ~reg_wdata_in[`AC_PACKER_LOAD]) begin
				packer_active_out <= 1'b0;
			end
		end
	end

	always @(posedge mclk_in) begin
		if (srst_in) begin
			mem_addr_out <= 16'h0000;
		end else begin
			mem_addr_out <= packer_active_out ? packer_cnt_q : normal_addr_in;
		end
	end

	// ----------------------------------------
	// Weight reload on upper address change
	// ----------------------------------------
	always @(posedge mclk_in) begin
		if (srst_in) begin
			waddr_prev_q      <= 16'h0000;
			weight_reload_out <= 1'b0;
		end else begin
			waddr_prev_q      <= weight_memory_addr_in;
			weight_reload_out <= ctrl_q[`AC_PACK_EXPRESS] &
				(weight_memory_addr_in[`WADDR_W-1:`WADDR_UPPER_LO] !=
				 waddr_prev_q[`WADDR_W-1:`WADDR_UPPER_LO]);
		end
	end

	// ----------------------------------------
	// Circular read buffer
	// ----------------------------------------
	always @(posedge mclk_in) begin
		if (srst_in) begin
			read_ptr_out <= 16'h0000;
		end else if (ctrl_q[`AC_SMALL_BUF] & ctrl_q[`AC_STREAM_EN]) begin
			if (read_buffer_step_in) begin
				read_ptr_out <= (read_ptr_out == read_buffer_end_in) ?
					layer_read_pointer_base_in : read_ptr_out + 16'h0001;
			end
		end else begin
			read_ptr_out <= layer_read_pointer_base_in;
		end
	end

	// ----------------------------------------
	// Data steering
	// ----------------------------------------
	// Lanes are built as nets so one process owns the whole output word
	wire [127:0] proc_data_d;

	genvar p;
	generate
		for (p = 0; p < 4; p = p + 1) begin : g_proc
			reg [31:0] lane_d;
			always @* begin
				lane_d = 32'h0000_0000;
				if (ctrl_q[`AC_QUAD_PACK]) begin
					lane_d = first_layer_data_out;
				end else if (ctrl_q[`AC_QUEUE_GROUP]) begin
					lane_d = {24'h000000, first_layer_data_out[p*8 +: 8]};
				end else if (p == 0) begin
					lane_d = first_layer_data_out;
				end
			end
			assign proc_data_d[p*32 +: 32] = lane_d;
		end
	endgenerate

	always @(posedge mclk_in) begin
		if (srst_in) begin
			proc_data_out <= 128'h0;
		end else begin
			proc_data_out <= proc_data_d;
		end
	end

	always @(posedge mclk_in) begin
		if (srst_in) begin
			first_layer_data_out <= 32'h0000_0000;
			fast_mem_data_out    <= 32'h0000_0000;
			fast_mem_we_out      <= 4'h0;
		end else begin
			first_layer_data_out <= ctrl_q[`AC_QUEUE_EN] ?
				queue_write_register_in : layer_data_in;
			fast_mem_data_out <= ctrl_q[`AC_FAST_TXQ] ? tx_queue_in : 32'h0000_0000;
			fast_mem_we_out   <= fast_lanes(ctrl_q[`AC_FAST_TXQ],
				ctrl_q[`AC_QUEUE_GROUP]);
		end
	end

	// ----------------------------------------
	// Queue mode
	// ----------------------------------------
	always @(posedge mclk_in) begin
		if (srst_in) begin
			queue_mode_out <= `QMODE_ONE_BYTE;
		end else begin
			queue_mode_out <= queue_mode_of(wide_data_in, chan_en_in);
		end
	end

	// ----------------------------------------
	// Mode outputs
	// ----------------------------------------
	always @(posedge mclk_in) begin
		if (srst_in) begin
			quad_pack_out       <= 1'b0;
			pool_wait_out       <= 1'b0;
			queue_clk_delay_out <= 6'h00;
			one_bit_weights_out <= 1'b0;
			accum_en_out        <= 1'b1;
			streaming_out       <= 1'b0;
		end else begin
			// Quad pack is passed as written; ordering against fast queue is software's job
			quad_pack_out       <= ctrl_q[`AC_QUAD_PACK];
			pool_wait_out       <= ctrl_q[`AC_POOL_SHIFT];
			queue_clk_delay_out <= ctrl_q[`AC_QDLY_HI:`AC_QDLY_LO];
			one_bit_weights_out <= ctrl_q[`AC_ONE_BIT];
			accum_en_out        <= ~ctrl_q[`AC_ONE_BIT];
			streaming_out       <= ctrl_q[`AC_STREAM_EN];
		end
	end

	// ----------------------------------------
	// Submodules
	// ----------------------------------------
	byte_pack_select u_pack (
		.mclk_in    (mclk_in),
		.srst_in    (srst_in),
		.sel_in     (ctrl_q[`AC_PACK_SEL_HI:`AC_PACK_SEL_LO]),
		.rdata_in   (mem_rdata_in),
		.packed_out (packed_byte_out)
	);

	pool_round u_pool (
		.mclk_in    (mclk_in),
		.srst_in    (srst_in),
		.round_in   (ctrl_q[`AC_POOL_ROUND]),
		.avg_in     (avg_pool_in),
		.sum_in     (pool_sum_in),
		.pooled_out (pooled_out)
	);

endmodule // array_control
`default_nettype wire

// *** hdl/byte_pack_select.v ***
// Purpose: Picks the packed byte out of a 32-bit memory read word.
// Assumes: Select is stable while data is read.
// Notes:   Registered output.
`timescale 1ns/1ps
`default_nettype none
`include "array_control_regs.vh"

module byte_pack_select (
	// Clock and reset
	input  wire        mclk_in,
	input  wire        srst_in,
	// Data
	input  wire [1:0]  sel_in,
	input  wire [31:0] rdata_in,
	output reg  [7:0]  packed_out
);

	// ----------------------------------------
	// Byte select
	// ----------------------------------------
	always @(posedge mclk_in) begin
		if (srst_in) begin
			packed_out <= 8'h00;
		end else begin
			case (sel_in)
				`PSEL_B0: packed_out <= rdata_in[7:0];
				`PSEL_B1: packed_out <= rdata_in[15:8];
				`PSEL_B2: packed_out <= rdata_in[23:16];
				`PSEL_B3: packed_out <= rdata_in[31:24];
				default:  packed_out <= 8'h00;
			endcase
		end
	end

endmodule // byte_pack_select
`default_nettype wire

// *** hdl/pool_round.v ***
// Purpose: Average pooling divide by four with optional half-up rounding.
// Assumes: Sum of four signed 8-bit values.
// Notes:   Without rounding the result truncates toward minus infinity.
`timescale 1ns/1ps
`default_nettype none

module pool_round (
	// Clock and reset
	input  wire        mclk_in,
	input  wire        srst_in,
	// Data
	input  wire        round_in,
	input  wire        avg_in,
	input  wire [9:0]  sum_in,
	output reg  [7:0]  pooled_out
);

	wire [10:0] rounded;

	// Adding half before the shift gives round up at 0.5 and above
	assign rounded = {sum_in[9], sum_in} + {9'h000, (round_in & avg_in), 1'b0};

	// ----------------------------------------
	// Output
	// ----------------------------------------
	always @(posedge mclk_in) begin
		if (srst_in) begin
			pooled_out <= 8'h00;
		end else begin
			pooled_out <= rounded[9:2];
		end
	end

endmodule // pool_round
`default_nettype wire

// *** inc/array_control_regs.vh ***
// Purpose: Constants for the array control register upper half.
// Assumes: One 32-bit register at offset 0x0 on the documented register port.
// Notes:   Bits 12 to 0 are held elsewhere and read as zero here.
`ifndef ARRAY_CONTROL_REGS_VH
`define ARRAY_CONTROL_REGS_VH

// ----------------------------------------
// Register map
// ----------------------------------------
`define AC_OFFSET          12'h000
`define AC_RESET           32'h0000_0000
`define AC_IMPL_MASK       32'hFFFF_E000

// ----------------------------------------
// Field positions
// ----------------------------------------
`define AC_QUAD_PACK       31
`define AC_POOL_SHIFT      30
`define AC_QDLY_HI         29
`define AC_QDLY_LO         24
`define AC_QUEUE_GROUP     23
`define AC_FAST_TXQ        22
`define AC_ONE_BIT         21
`define AC_PACK_EXPRESS    20
`define AC_SMALL_BUF       19
`define AC_PACK_SEL_HI     18
`define AC_PACK_SEL_LO     17
`define AC_PACKER_LOAD     16
`define AC_QUEUE_EN        15
`define AC_STREAM_EN       14
`define AC_POOL_ROUND      13

// ----------------------------------------
// Widths and encodings
// ----------------------------------------
`define QDLY_W             6
`define QDLY_MAX           6'h3F
`define WADDR_W            16
`define WADDR_UPPER_LO     8
`define PSEL_B0            2'h0
`define PSEL_B1            2'h1
`define PSEL_B2            2'h2
`define PSEL_B3            2'h3
`define QMODE_ONE_BYTE     2'h0
`define QMODE_WIDE         2'h1
`define QMODE_FOUR_BYTE    2'h2

`endif
